/* hdl/cbfm_consts.svh */
// Constants for the breaker failure monitor: widths, reset values and timing.
// Assumes inclusion from the package and design files by bare name.
`ifndef CBFM_CONSTS_SVH
`define CBFM_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define CBFM_MAG_W 16
`define CBFM_PTHR_W 12
`define CBFM_DLY_W 19

// ----------------------------------------------------------------------------
// Reset values (phase in 0.01 In, residual in 0.001 In, delays in 5 ms steps)
// ----------------------------------------------------------------------------
`define CBFM_PTHR_RST 12'h014
`define CBFM_RTHR_RST 16'h04B0
`define CBFM_RETRIP_DLY_RST 19'h00014
`define CBFM_FAIL_DLY_RST 19'h00028

// ----------------------------------------------------------------------------
// Scaling and timing
// ----------------------------------------------------------------------------
`define CBFM_PHASE_SCALE 16'h000A
`define CBFM_HYST_NUM 7'h61
`define CBFM_HYST_DEN 7'h64
`define CBFM_TICK_NS 5000000
`define CBFM_CLK_NS 25

`endif

/* hdl/cbfm_monitor.sv */
// Breaker failure monitor top: pick-up, start combination, blocking, timers, forcing.
// Assumes measurements, trip events, relay controls and block come from logic on clock_i.
`timescale 1ns/10ps
`include "cbfm_consts.svh"

module cbfm_monitor
   import cbfm_pkg::*;
#(
   parameter int N_SIG = 16,
   parameter int N_DO = 8,
   parameter int TICK_CYCLES = `CBFM_TICK_NS / `CBFM_CLK_NS
)
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire cbfm_meas_s meas_i,
   input wire logic [N_SIG-1:0] trip_event_i,
   input wire logic [N_DO-1:0] relay_ctrl_i,
   input wire logic block_i,
   input wire logic static_load_i,
   input wire cbfm_static_s static_i,
   input wire logic [N_SIG-1:0] signal_mask_i,
   input wire logic [N_DO-1:0] relay_mask_i,
   input wire logic group_load_i,
   input wire cbfm_group_s group_i,
   input wire logic retrip_enable_i,
   input wire logic force_enable_i,
   output cbfm_state_e state_o,
   output logic start_o,
   output logic blocked_o,
   output logic retrip_o,
   output logic breaker_fail_output_o,
   output logic tick_o
);

   generate
      if (TICK_CYCLES < 4 || N_SIG < 1 || N_DO < 1)
         $error("cbfm_monitor: unsupported parameter values");
   endgenerate

   // ----------------------------------------------------------------------------
   // Processing tick
   // ----------------------------------------------------------------------------
   localparam int TW = $clog2(TICK_CYCLES);

   logic [TW-1:0] tick_cnt_q;
   logic tick_q;
   logic eval_q;
   logic tick_wrap;

   assign tick_wrap = tick_cnt_q == TW'(TICK_CYCLES - 1);

   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
         eval_q <= 1'b0;
      end
      else
      begin
         tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + 1'b1;
         tick_q <= tick_wrap;
         eval_q <= tick_q;
      end
   end

   // ----------------------------------------------------------------------------
   // Settings
   // ----------------------------------------------------------------------------
   cbfm_static_s static_q;
   cbfm_group_s group_q;
   logic [N_SIG-1:0] signal_mask_q;
   logic [N_DO-1:0] relay_mask_q;

   // static set has its own load
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         static_q <= '{CBFM_MODE_CUR, CBFM_RES_NONE, CBFM_ST_NORMAL};
         signal_mask_q <= '0;
         relay_mask_q <= '0;
      end
      else if (static_load_i)
      begin
         static_q <= static_i;
         signal_mask_q <= signal_mask_i;
         relay_mask_q <= relay_mask_i;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (reset_i)
         group_q <= '{`CBFM_PTHR_RST, `CBFM_RTHR_RST, `CBFM_RETRIP_DLY_RST, `CBFM_FAIL_DLY_RST};
      else if (group_load_i)
         group_q <= group_i;
   end

   // ----------------------------------------------------------------------------
   // Current pick-up
   // ----------------------------------------------------------------------------
   logic [`CBFM_MAG_W-1:0] phase_thr;
   logic [`CBFM_MAG_W-1:0] res_mag;
   logic [`CBFM_MAG_W-1:0] phase_mag [3];
   logic [2:0] phase_pick;
   logic res_pick;
   logic res_en;

   // shared phase threshold, scaled to 0.001 In
   assign phase_thr = `CBFM_MAG_W'(group_q.phase_pickup_threshold) * `CBFM_PHASE_SCALE;
   assign phase_mag[0] = meas_i.phase_a_magnitude;
   assign phase_mag[1] = meas_i.phase_b_magnitude;
   assign phase_mag[2] = meas_i.phase_c_magnitude;

   assign res_mag = (static_q.residual_source_select == CBFM_RES_ONE) ? meas_i.residual_input_one :
                    (static_q.residual_source_select == CBFM_RES_TWO) ? meas_i.residual_input_two :
                    meas_i.calculated_residual;
   assign res_en = static_q.residual_source_select != CBFM_RES_NONE;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_phase
         cbfm_pickup u_pick (
            .clock_i(clock_i),
            .reset_i(reset_i),
            .tick_i(tick_q),
            .enable_i(1'b1),
            .magnitude_i(phase_mag[gi]),
            .threshold_i(phase_thr),
            .active_o(phase_pick[gi])
         );
      end
   endgenerate

   cbfm_pickup u_res_pick (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .tick_i(tick_q),
      .enable_i(res_en),
      .magnitude_i(res_mag),
      .threshold_i(group_q.residual_pickup_threshold),
      .active_o(res_pick)
   );

   // ----------------------------------------------------------------------------
   // Start combination
   // ----------------------------------------------------------------------------
   logic cur_c;
   logic sig_c;
   logic do_c;
   logic cond;

   assign cur_c = |phase_pick || res_pick;
   // trip mask used only in signal modes below
   assign sig_c = |(trip_event_i & signal_mask_q);
   // relay mask used only in relay modes below
   assign do_c = |(relay_ctrl_i & relay_mask_q);

   always_comb
   begin
      case (static_q.mode)
         CBFM_MODE_CUR: cond = cur_c;
         CBFM_MODE_DO: cond = do_c;
         CBFM_MODE_SIG: cond = sig_c;
         CBFM_MODE_CUR_AND_DO: cond = cur_c && do_c;
         CBFM_MODE_CUR_AND_SIG: cond = cur_c && sig_c;
         CBFM_MODE_SIG_AND_DO: cond = sig_c && do_c;
         CBFM_MODE_CUR_OR_DO: cond = cur_c || do_c;
         CBFM_MODE_CUR_OR_SIG: cond = cur_c || sig_c;
         CBFM_MODE_SIG_OR_DO: cond = sig_c || do_c;
         CBFM_MODE_ALL_AND: cond = cur_c && sig_c && do_c;
         CBFM_MODE_ALL_OR: cond = cur_c || sig_c || do_c;
         default: cond = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------------
   // Blocking and timers
   // ----------------------------------------------------------------------------
   logic cond_q;
   logic block_q;
   logic run;
   logic retrip_exp;
   logic fail_exp;

   // block sampled with the start condition once per processing tick, on eval_q
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         cond_q <= 1'b0;
         block_q <= 1'b0;
      end
      else if (eval_q)
      begin
         cond_q <= cond;
         block_q <= block_i;
      end
   end

   assign run = cond && !block_i;

   cbfm_timer u_retrip_tmr (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .tick_i(eval_q),
      .run_i(run),
      .delay_i(group_q.retrip_delay),
      .expired_o(retrip_exp)
   );

   cbfm_timer u_fail_tmr (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .tick_i(eval_q),
      .run_i(run),
      .delay_i(group_q.fail_delay),
      .expired_o(fail_exp)
   );

   // ----------------------------------------------------------------------------
   // State and outputs
   // ----------------------------------------------------------------------------
   cbfm_state_e nat_state;
   cbfm_state_e state_d;
   logic retrip_nat;
   logic fail_nat;
   logic retrip_d;
   logic fail_d;

   // retrip gated by start, block and its enable
   assign retrip_nat = cond_q && !block_q && retrip_exp && retrip_enable_i;
   // failure output after the longer delay
   assign fail_nat = cond_q && !block_q && fail_exp;
   assign nat_state = !cond_q ? CBFM_ST_NORMAL :
                      block_q ? CBFM_ST_BLOCKED :
                      fail_nat ? CBFM_ST_FAIL :
                      retrip_nat ? CBFM_ST_RETRIP : CBFM_ST_START;
   assign state_d = force_enable_i ? static_q.forced_state_select : nat_state;
   assign retrip_d = force_enable_i ? state_d == CBFM_ST_RETRIP : retrip_nat;
   assign fail_d = force_enable_i ? state_d == CBFM_ST_FAIL : fail_nat;

   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         state_o <= CBFM_ST_NORMAL;
         start_o <= 1'b0;
         blocked_o <= 1'b0;
         retrip_o <= 1'b0;
         breaker_fail_output_o <= 1'b0;
         tick_o <= 1'b0;
      end
      else
      begin
         state_o <= state_d;
         start_o <= state_d == CBFM_ST_START || state_d == CBFM_ST_RETRIP || state_d == CBFM_ST_FAIL;
         blocked_o <= state_d == CBFM_ST_BLOCKED;
         retrip_o <= retrip_d;
         breaker_fail_output_o <= fail_d;
         tick_o <= eval_q;
      end
   end

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   a_retrip_disabled: assert property (@(posedge clock_i) disable iff (reset_i)
      !retrip_enable_i && !force_enable_i |=> !retrip_o)
      else $error("retrip asserted while disabled");
   a_blocked_no_start: assert property (@(posedge clock_i) disable iff (reset_i)
      blocked_o |-> !start_o && !retrip_o && !breaker_fail_output_o)
      else $error("start or trip while blocked");
   a_forced_state: assert property (@(posedge clock_i) disable iff (reset_i)
      force_enable_i |=> state_o == $past(static_q.forced_state_select))
      else $error("forced state not shown");
   a_tick_spacing: assert property (@(posedge clock_i) disable iff (reset_i)
      tick_q |=> !tick_q [*3])
      else $error("processing ticks too close");
   a_fail_needs_start: assert property (@(posedge clock_i) disable iff (reset_i)
      !force_enable_i && !cond_q |=> !breaker_fail_output_o && !retrip_o)
      else $error("trip output without start");

endmodule

/* hdl/cbfm_pickup.sv */
// One current pick-up element with built-in release hysteresis.
// Assumes magnitude and threshold share one scale and tick_i is a one-cycle pulse.
`timescale 1ns/10ps
`include "cbfm_consts.svh"

module cbfm_pickup
   import cbfm_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic tick_i,
   input wire logic enable_i,
   input wire logic [`CBFM_MAG_W-1:0] magnitude_i,
   input wire logic [`CBFM_MAG_W-1:0] threshold_i,
   output logic active_o
);

   logic active_q;
   logic active_d;
   logic above;
   logic below_release;
   logic [22:0] mag_scaled;
   logic [22:0] thr_scaled;

   assign mag_scaled = 23'(magnitude_i) * 23'(`CBFM_HYST_DEN);
   assign thr_scaled = 23'(threshold_i) * 23'(`CBFM_HYST_NUM);
   assign above = magnitude_i > threshold_i;
   assign below_release = mag_scaled < thr_scaled;
   assign active_d = !enable_i ? 1'b0 : above ? 1'b1 : below_release ? 1'b0 : active_q;

   always_ff @(posedge clock_i)
   begin
      if (reset_i)
         active_q <= 1'b0;
      else if (tick_i)
         active_q <= active_d;
   end

   assign active_o = active_q;

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   a_pickup_set: assert property (@(posedge clock_i) disable iff (reset_i)
      tick_i && enable_i && above |=> active_q)
      else $error("pickup did not set above threshold");
   a_hyst_hold: assert property (@(posedge clock_i) disable iff (reset_i)
      tick_i && enable_i && active_q && !below_release |=> active_q)
      else $error("pickup released inside hysteresis band");
   a_disabled_off: assert property (@(posedge clock_i) disable iff (reset_i)
      tick_i && !enable_i |=> !active_q)
      else $error("disabled pickup active");

endmodule

/* hdl/cbfm_pkg.sv */
// Types shared by the breaker failure monitor files.
// Assumes cbfm_consts.svh is on the include path.
`include "cbfm_consts.svh"

package cbfm_pkg;

   typedef enum logic [3:0] {
      CBFM_MODE_CUR,
      CBFM_MODE_DO,
      CBFM_MODE_SIG,
      CBFM_MODE_CUR_AND_DO,
      CBFM_MODE_CUR_AND_SIG,
      CBFM_MODE_SIG_AND_DO,
      CBFM_MODE_CUR_OR_DO,
      CBFM_MODE_CUR_OR_SIG,
      CBFM_MODE_SIG_OR_DO,
      CBFM_MODE_ALL_AND,
      CBFM_MODE_ALL_OR
   } cbfm_mode_e;

   typedef enum logic [1:0] {
      CBFM_RES_NONE,
      CBFM_RES_ONE,
      CBFM_RES_TWO,
      CBFM_RES_CALC
   } cbfm_res_e;

   typedef enum logic [2:0] {
      CBFM_ST_NORMAL,
      CBFM_ST_START,
      CBFM_ST_RETRIP,
      CBFM_ST_FAIL,
      CBFM_ST_BLOCKED
   } cbfm_state_e;

   typedef struct packed {
      logic [`CBFM_MAG_W-1:0] phase_a_magnitude;
      logic [`CBFM_MAG_W-1:0] phase_b_magnitude;
      logic [`CBFM_MAG_W-1:0] phase_c_magnitude;
      logic [`CBFM_MAG_W-1:0] residual_input_one;
      logic [`CBFM_MAG_W-1:0] residual_input_two;
      logic [`CBFM_MAG_W-1:0] calculated_residual;
   } cbfm_meas_s;

   typedef struct packed {
      cbfm_mode_e mode;
      cbfm_res_e residual_source_select;
      cbfm_state_e forced_state_select;
   } cbfm_static_s;

   typedef struct packed {
      logic [`CBFM_PTHR_W-1:0] phase_pickup_threshold;
      logic [`CBFM_MAG_W-1:0] residual_pickup_threshold;
      logic [`CBFM_DLY_W-1:0] retrip_delay;
      logic [`CBFM_DLY_W-1:0] fail_delay;
   } cbfm_group_s;

endpackage

/* hdl/cbfm_timer.sv */
// Definite-time delay counter stepped on the processing tick.
// Assumes tick_i is a one-cycle pulse and delay_i counts ticks.
`timescale 1ns/10ps
`include "cbfm_consts.svh"

module cbfm_timer
   import cbfm_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic tick_i,
   input wire logic run_i,
   input wire logic [`CBFM_DLY_W-1:0] delay_i,
   output logic expired_o
);

   logic [`CBFM_DLY_W-1:0] count_q;
   logic expired_q;
   logic reached;

   assign reached = count_q >= delay_i;

   always_ff @(posedge clock_i)
   begin
      if (reset_i || (tick_i && !run_i))
      begin
         count_q <= '0;
         expired_q <= 1'b0;
      end
      else if (tick_i && reached)
         expired_q <= 1'b1;
      else if (tick_i)
         count_q <= count_q + 1'b1;
   end

   assign expired_o = expired_q;

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   a_timer_clear: assert property (@(posedge clock_i) disable iff (reset_i)
      tick_i && !run_i |=> count_q == '0 && !expired_q)
      else $error("timer not cleared when start dropped");
   a_timer_expire: assert property (@(posedge clock_i) disable iff (reset_i)
      tick_i && run_i && reached |=> expired_q)
      else $error("timer did not expire at delay");
   a_timer_early: assert property (@(posedge clock_i) disable iff (reset_i)
      !expired_q ##1 expired_q |-> $past(count_q) >= $past(delay_i))
      else $error("timer expired early");

endmodule

/* test/cbfm_front_model.sv */
// Behavioural measurement front end and binary-signal source for the monitor.
// Assumes the bench sets request values once per processing cycle on clock_i.
`timescale 1ns/10ps

module cbfm_front_model
   import cbfm_pkg::*;
#(
   parameter int N_SIG = 16,
   parameter int N_DO = 8
)
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire cbfm_meas_s meas_req_i,
   input wire logic [N_SIG-1:0] trip_req_i,
   input wire logic [N_DO-1:0] relay_req_i,
   input wire logic block_req_i,
   output cbfm_meas_s meas_o,
   output logic [N_SIG-1:0] trip_event_o,
   output logic [N_DO-1:0] relay_ctrl_o,
   output logic block_o
);

   // ------
   // Refresh stage
   // ------
   // Republished every clock so the monitor only ever sees a settled level
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         meas_o <= '0;
         trip_event_o <= '0;
         relay_ctrl_o <= '0;
         block_o <= 1'b0;
      end
      else
      begin
         meas_o <= meas_req_i;
         trip_event_o <= trip_req_i;
         relay_ctrl_o <= relay_req_i;
         block_o <= block_req_i;
      end
   end

endmodule

/* test/tb_cbfm_monitor.sv */
// Self-checking bench for the breaker failure monitor with a reference model.
// Assumes TICK_CYCLES of 8 and inputs changed only just after tick_o.
`timescale 1ns/10ps

module tb_cbfm_monitor
   import cbfm_pkg::*;
;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   cbfm_meas_s meas_req = '0;
   cbfm_meas_s meas;
   logic [15:0] trip_req = '0;
   logic [15:0] trip;
   logic [7:0] relay_req = '0;
   logic [7:0] relay;
   logic block_req = 1'b0;
   logic block;
   logic static_load = 1'b0;
   cbfm_static_s static_req = '0;
   logic [15:0] signal_mask = '0;
   logic [7:0] relay_mask = '0;
   logic group_load = 1'b0;
   cbfm_group_s group_req = '0;
   logic retrip_en = 1'b1;
   logic force_en = 1'b0;
   cbfm_state_e state;
   logic start, blocked, retrip, fail, tick;
   // Reference model copies of the settings and inputs
   cbfm_meas_s mm = '0;
   logic [15:0] mt = '0;
   logic [15:0] sm = '0;
   logic [7:0] mr = '0;
   logic [7:0] rm = '0;
   logic mb = 1'b0;
   logic ren = 1'b1;
   logic fen = 1'b0;
   cbfm_mode_e md = CBFM_MODE_CUR;
   cbfm_res_e rs = CBFM_RES_NONE;
   cbfm_state_e fs = CBFM_ST_NORMAL;
   logic [11:0] pt = 12'h014;
   logic [15:0] rt = 16'h04B0;
   logic [18:0] rd = 19'h00014;
   logic [18:0] fd = 19'h00028;
   logic [3:0] pk = '0;
   int cnt = 0;
   logic was_run = 1'b0;
   logic [31:0] rnd = 32'h0A200DD5;
   logic [6:0] exp_q[$];
   logic [6:0] e;
   int failures = 0;
   int checks = 0;

   always #12.5 clock_i = ~clock_i;

   cbfm_front_model cbfm_front_model_i (.clock_i(clock_i), .reset_i(reset_i),
      .meas_req_i(meas_req), .trip_req_i(trip_req), .relay_req_i(relay_req),
      .block_req_i(block_req), .meas_o(meas), .trip_event_o(trip), .relay_ctrl_o(relay),
      .block_o(block));

   cbfm_monitor #(.N_SIG(16), .N_DO(8), .TICK_CYCLES(8)) cbfm_monitor_i (.clock_i(clock_i),
      .reset_i(reset_i), .meas_i(meas), .trip_event_i(trip), .relay_ctrl_i(relay),
      .block_i(block), .static_load_i(static_load), .static_i(static_req),
      .signal_mask_i(signal_mask), .relay_mask_i(relay_mask), .group_load_i(group_load),
      .group_i(group_req), .retrip_enable_i(retrip_en), .force_enable_i(force_en),
      .state_o(state), .start_o(start), .blocked_o(blocked), .retrip_o(retrip),
      .breaker_fail_output_o(fail), .tick_o(tick));

   // ------
   // Helpers
   // ------
   function automatic logic [31:0] xs(logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction

   task automatic check(string what, logic [7:0] seen, logic [7:0] want);
      checks++;
      if (seen !== want)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic wrap_up();
      if (failures == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Predicts the outputs after the next evaluation
   task automatic predict();
      int mag[4];
      int thr;
      logic cu, sg, dq, cond, run, rx, fx;
      cbfm_state_e st;
      mag[0] = mm.phase_a_magnitude;
      mag[1] = mm.phase_b_magnitude;
      mag[2] = mm.phase_c_magnitude;
      mag[3] = rs == CBFM_RES_ONE ? mm.residual_input_one :
               rs == CBFM_RES_TWO ? mm.residual_input_two : mm.calculated_residual;
      for (int i = 0; i < 4; i++)
      begin
         thr = (i < 3) ? pt * 10 : rt;
         if (i == 3 && rs == CBFM_RES_NONE)
            pk[i] = 1'b0;
         else if (mag[i] > thr)
            pk[i] = 1'b1;
         else if (mag[i] * 100 < thr * 97)
            pk[i] = 1'b0;
      end
      cu = |pk;
      sg = |(mt & sm);
      dq = |(mr & rm);
      case (md)
         CBFM_MODE_CUR: cond = cu;
         CBFM_MODE_DO: cond = dq;
         CBFM_MODE_SIG: cond = sg;
         CBFM_MODE_CUR_AND_DO: cond = cu & dq;
         CBFM_MODE_CUR_AND_SIG: cond = cu & sg;
         CBFM_MODE_SIG_AND_DO: cond = sg & dq;
         CBFM_MODE_CUR_OR_DO: cond = cu | dq;
         CBFM_MODE_CUR_OR_SIG: cond = cu | sg;
         CBFM_MODE_SIG_OR_DO: cond = sg | dq;
         CBFM_MODE_ALL_AND: cond = cu & sg & dq;
         CBFM_MODE_ALL_OR: cond = cu | sg | dq;
         default: cond = 1'b0;
      endcase
      run = cond && !mb;
      cnt = (run && was_run) ? cnt + 1 : 0;
      was_run = run;
      rx = run && cnt >= rd;
      fx = run && cnt >= fd;
      st = !run ? (cond ? CBFM_ST_BLOCKED : CBFM_ST_NORMAL) :
           fx ? CBFM_ST_FAIL : (rx && ren) ? CBFM_ST_RETRIP : CBFM_ST_START;
      if (fen)
         exp_q.push_back({fs, fs inside {CBFM_ST_START, CBFM_ST_RETRIP, CBFM_ST_FAIL},
                          fs == CBFM_ST_BLOCKED, fs == CBFM_ST_RETRIP, fs == CBFM_ST_FAIL});
      else
         exp_q.push_back({st, run, cond && mb, rx && ren, fx});
   endtask

   task automatic run(int n);
      repeat (n)
      begin
         meas_req <= mm;
         trip_req <= mt;
         relay_req <= mr;
         block_req <= mb;
         retrip_en <= ren;
         force_en <= fen;
         predict();
         @(posedge clock_i iff tick === 1'b1);
      end
   endtask

   task automatic load_static(cbfm_mode_e m, cbfm_res_e r, cbfm_state_e f, logic [15:0] s,
                              logic [7:0] d);
      md = m;
      rs = r;
      fs = f;
      sm = s;
      rm = d;
      static_req <= {m, r, f};
      signal_mask <= s;
      relay_mask <= d;
      static_load <= 1'b1;
      @(posedge clock_i);
      static_load <= 1'b0;
   endtask

   task automatic load_group(logic [11:0] p, logic [15:0] r, logic [18:0] a, logic [18:0] b);
      pt = p;
      rt = r;
      rd = a;
      fd = b;
      group_req <= {p, r, a, b};
      group_load <= 1'b1;
      @(posedge clock_i);
      group_load <= 1'b0;
   endtask

   // ------
   // Output watcher
   // ------
   // Outputs update at the edge that samples tick high, so read them half a cycle later
   always @(posedge clock_i iff tick === 1'b1)
   begin
      @(negedge clock_i);
      if (exp_q.size() == 0)
      begin
         failures++;
         $display("[FAIL] expectation queue expected entry seen empty");
      end
      else
      begin
         e = exp_q.pop_front();
         check("state_o", {5'h00, state}, {5'h00, e[6:4]});
         check("start_o", {7'h00, start}, {7'h00, e[3]});
         check("blocked_o", {7'h00, blocked}, {7'h00, e[2]});
         check("retrip_o", {7'h00, retrip}, {7'h00, e[1]});
         check("breaker_fail_output_o", {7'h00, fail}, {7'h00, e[0]});
         check("tick_o", {7'h00, tick}, 8'h00);
      end
   end

   initial
   begin
      repeat (6000) @(posedge clock_i);
      failures++;
      wrap_up();
   end

   // ------
   // Scenarios
   // ------
   initial
   begin
      repeat (10) @(posedge clock_i);
      reset_i <= 1'b0;
      mm.phase_a_magnitude = 16'h00C8;
      mm.residual_input_one = 16'h1388;
      run(3);
      mm.phase_a_magnitude = 16'h00C9;
      run(44);
      mm.phase_a_magnitude = 16'h00C2;
      run(2);
      mm.phase_a_magnitude = 16'h00C1;
      run(2);
      load_group(12'h014, 16'h04B0, 19'h00002, 19'h00004);
      for (int s = 1; s < 4; s++)
      begin
         load_static(CBFM_MODE_CUR, cbfm_res_e'(s), CBFM_ST_NORMAL, 16'h0000, 8'h00);
         mm = {48'h0, {3{16'h04B1}}};
         mm[(3 - s) * 16 +: 16] = 16'h04B0;
         run(2);
         mm = '0;
         mm[(3 - s) * 16 +: 16] = 16'h04B1;
         run(2);
         mm = '0;
         run(1);
      end
      for (int p = 0; p < 3; p++)
      begin
         mm = '0;
         mm[(5 - p) * 16 +: 16] = 16'h00C9;
         run(2);
      end
      mm = '0;
      run(1);
      mm.phase_a_magnitude = 16'h00C9;
      mb = 1'b1;
      run(2);
      mb = 1'b0;
      run(2);
      mb = 1'b1;
      run(1);
      mb = 1'b0;
      run(5);
      ren = 1'b0;
      run(6);
      ren = 1'b1;
      mm = '0;
      run(1);
      mm.phase_a_magnitude = 16'h00C9;
      run(3);
      load_group(12'h028, 16'h04B0, 19'h00002, 19'h00004);
      run(2);
      load_static(CBFM_MODE_CUR, CBFM_RES_NONE, CBFM_ST_NORMAL, 16'h0000, 8'h00);
      mm.phase_a_magnitude = 16'h0191;
      run(2);
      load_group(12'h014, 16'h04B0, 19'h00002, 19'h00004);
      mm = '0;
      run(1);
      fen = 1'b1;
      for (int f = 0; f < 5; f++)
      begin
         load_static(CBFM_MODE_CUR, CBFM_RES_NONE, cbfm_state_e'(f), 16'h0000, 8'h00);
         run(2);
      end
      fen = 1'b0;
      run(1);
      for (int m = 0; m < 12; m++)
      begin
         rnd = xs(rnd);
         load_static(cbfm_mode_e'(m), cbfm_res_e'(rnd[1:0]), CBFM_ST_NORMAL, rnd[31:16],
                     rnd[15:8]);
         repeat (5)
         begin
            rnd = xs(rnd);
            mm.phase_a_magnitude = 16'h00B4 + 16'(rnd[4:0]);
            mm.phase_b_magnitude = 16'h00B4 + 16'(rnd[9:5]);
            mm.phase_c_magnitude = 16'h00B4 + 16'(rnd[14:10]);
            mm.residual_input_one = 16'h049C + 16'(rnd[20:15]);
            mm.residual_input_two = 16'h049C + 16'(rnd[26:21]);
            mm.calculated_residual = 16'h049C + 16'(rnd[31:27]);
            rnd = xs(rnd);
            mt = rnd[0] ? 16'h0001 << rnd[4:1] : 16'h0000;
            mr = rnd[5] ? 8'h01 << rnd[8:6] : 8'h00;
            mb = rnd[11:9] == 3'h0;
            ren = rnd[12];
            run(1);
         end
      end
      repeat (2) @(posedge clock_i);
      wrap_up();
   end

endmodule
